//--- src/gate_protect_pkg.sv
package gate_protect_pkg;

  // ----------------------------------------------------------------
  // register selection and reset values
  // ----------------------------------------------------------------
  localparam logic REG_SEL_ENABLE = 1'b0;
  localparam logic REG_SEL_TURNOFF = 1'b1;
  localparam logic [15:0] ENABLE_RESET = 16'h0934;
  localparam logic [15:0] TURNOFF_RESET = 16'h7741;

  // ----------------------------------------------------------------
  // protection_enable_config field positions
  // ----------------------------------------------------------------
  localparam int POS_SEC_POS_UNDERVOLT_OFF = 15;
  localparam int POS_THERMAL_FILTER_HI = 14;
  localparam int POS_THERMAL_FILTER_LO = 13;
  localparam int POS_DESAT_FILTER = 12;
  localparam int POS_SEC_POS_OVERVOLT_OFF = 11;
  localparam int POS_MILLER_SOURCE = 10;
  localparam int POS_GM_BLANK_HI = 9;
  localparam int POS_GM_BLANK_LO = 8;
  localparam int POS_GATE_MONITOR_OFF = 7;
  localparam int POS_MILLER_CLAMP_OFF = 6;
  localparam int POS_COLLECTOR_CLAMP_ON = 5;
  localparam int POS_DESAT_DETECT_ON = 4;
  localparam int POS_SHORT_CIRCUIT_OFF = 3;
  localparam int POS_OVERCURRENT_OFF = 2;
  localparam int POS_SWITCH_THERMAL_ON = 1;
  localparam int POS_SEC_NEG_LOCKOUT_ON = 0;

  // ----------------------------------------------------------------
  // turnoff_threshold_config field positions
  // ----------------------------------------------------------------
  localparam int POS_GM_MUTE_TURNOFF = 15;
  localparam int POS_DESAT_TH_HI = 14;
  localparam int POS_DESAT_TH_LO = 11;
  localparam int POS_CHARGE_CUR_HI = 10;
  localparam int POS_CHARGE_CUR_LO = 9;
  localparam int POS_DESAT_PULLDOWN_ON = 8;
  localparam int POS_MILLER_TH_HI = 7;
  localparam int POS_MILLER_TH_LO = 6;
  localparam int POS_SOFT_CUR_HI = 5;
  localparam int POS_SOFT_CUR_LO = 4;
  localparam int POS_TURNOFF_MODE_HI = 3;
  localparam int POS_TURNOFF_MODE_LO = 1;
  localparam int POS_PWM_MUTE_ON = 0;

  // ----------------------------------------------------------------
  // turn-off mode encoding
  // ----------------------------------------------------------------
  localparam int MODE_TWO_LEVEL_BIT = 2;
  localparam logic [1:0] COVER_NONE = 2'h0;
  localparam logic [1:0] COVER_SC_DESAT = 2'h1;
  localparam logic [1:0] COVER_PLUS_OC = 2'h2;
  localparam logic [1:0] COVER_PLUS_THERMAL = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int THERMAL_FILTER_NS_0 = 250;
  localparam int THERMAL_FILTER_NS_1 = 500;
  localparam int THERMAL_FILTER_NS_2 = 750;
  localparam int THERMAL_FILTER_NS_3 = 1000;
  localparam int DESAT_FILTER_NS_0 = 158;
  localparam int DESAT_FILTER_NS_1 = 316;
  localparam int GM_BLANK_NS_0 = 500;
  localparam int GM_BLANK_NS_1 = 1000;
  localparam int GM_BLANK_NS_2 = 2500;
  localparam int GM_BLANK_NS_3 = 4000;
  localparam int PWM_MUTE_NS = 1000;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // analog setting scales
  // ----------------------------------------------------------------
  localparam int DESAT_TH_BASE_MV = 2500;
  localparam int DESAT_TH_STEP_MV = 500;

endpackage : gate_protect_pkg

//--- src/cfg_word.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_word #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, active high
  input wire logic wr_en, // write strobe for this word
  input wire logic [15:0] wr_data, // value to store
  output logic [15:0] value // stored word
);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data; // R20
    end
  end

endmodule : cfg_word
`default_nettype wire

//--- src/gate_driver_protection_config.sv
// Functional notes
// R1: enable bit 15 low keeps positive supply undervoltage lockout; resets 0.
// R2: thermal filter code 0..3 gives 250/500/750/1000 ns; resets 0.
// R3: desaturation filter bit gives 158 ns or 316 ns; resets 0.
// R4: bit 11 high turns positive supply overvoltage lockout off; resets 1.
// R5: bit 10 picks internal clamp (0) or external transistor (1); resets 0.
// R6: gate monitor blanking code gives 500/1000/2500/4000 ns; resets 1.
// R7: bit 7 high switches gate monitor off; resets 0.
// R8: bit 6 high switches Miller clamp off; resets 0.
// R9: bit 3 high switches short-circuit protection off; resets 0.
// R10: bit 2 high switches overcurrent protection off; resets 1.
// R11: bit 1 high switches power switch thermal shutdown on; resets 0.
// R12: bit 0 high enables negative supply under and overvoltage lockout; resets 0.
// R13: second word bit 15 high hides gate monitor faults during fault turn-off.
// R14: threshold field 14:11 is 2.5 V plus code times 500 mV; resets 0xE.
// R15: charge current code gives 0.6/0.7/0.8/1 mA; resets 3.
// R16: bit 8 high switches desaturation pull-down on; resets 1.
// R17: Miller clamp threshold code gives 1.5/2/3/4 V; resets 1.
// R18: mode 1-3 soft, 5-7 two-level, widening fault coverage; 0,4 off.
// R19: bit 0 high mutes PWM for mute interval after SC/OC/OT; resets 1.
// R20: each field holds its written value until rewritten or reset.
`timescale 1ns/1ps
`default_nettype none
module gate_driver_protection_config (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic reset, // async reset, active high
  input wire logic wr_en, // register write strobe
  input wire logic wr_sel, // 0 enable word, 1 turn-off word
  input wire logic [15:0] wr_data, // write data
  input wire logic rd_sel, // 0 enable word, 1 turn-off word
  output logic [15:0] rd_data, // registered read data
  input wire logic desat_in, // desaturation comparator pin
  input wire logic short_circuit_in, // short-circuit comparator pin
  input wire logic overcurrent_in, // overcurrent comparator pin
  input wire logic switch_thermal_in, // power switch thermal comparator pin
  input wire logic gate_monitor_in, // gate voltage monitor mismatch pin
  input wire logic pwm_in, // incoming PWM pin
  output logic sec_pos_undervolt_off, // positive supply UVLO disabled
  output logic sec_pos_overvolt_off, // positive supply OVLO disabled
  output logic miller_clamp_source_select, // 0 internal, 1 external clamp
  output logic miller_clamp_off, // Miller clamp disabled
  output logic collector_clamp_on, // collector-emitter clamp enabled
  output logic desaturation_pulldown_on, // desat pull-down current on
  output logic sec_neg_supply_lockout_on, // negative supply lockout on
  output logic [3:0] desaturation_threshold, // threshold code
  output logic [15:0] desaturation_threshold_mv, // threshold in mV
  output logic [15:0] blank_cap_charge_current_ua, // charge current in uA
  output logic [15:0] miller_clamp_threshold_mv, // clamp threshold in mV
  output logic [1:0] soft_turnoff_current, // soft turn-off current code
  output logic desat_fault, // filtered desaturation fault
  output logic short_circuit_fault, // enabled short-circuit fault
  output logic overcurrent_fault, // enabled overcurrent fault
  output logic switch_thermal_fault, // filtered thermal fault
  output logic gate_monitor_fault, // unblanked gate monitor fault
  output logic soft_turnoff, // soft turn-off request
  output logic two_level_turnoff, // two-level turn-off request
  output logic pwm_out // PWM after muting
);
  import gate_protect_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] ns_to_cycles(input int ns);
    int cyc;
    cyc = (ns * CLK_MHZ + 999) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return CNT_W'(cyc);
  endfunction : ns_to_cycles

  function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] cnt,
                                                  input logic [CNT_W-1:0] lim);
    return (cnt < lim) ? cnt + CNT_W'(1) : cnt;
  endfunction : count_step

  localparam logic [CNT_W-1:0] MUTE_CYCLES = ns_to_cycles(PWM_MUTE_NS);

  // ----------------------------------------------------------------
  // configuration words
  // ----------------------------------------------------------------
  logic [15:0] enable_word;
  logic [15:0] turnoff_word;

  cfg_word #(.RESET_VALUE(ENABLE_RESET)) u_protection_enable_config (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(wr_en && wr_sel == REG_SEL_ENABLE),
    .wr_data(wr_data),
    .value(enable_word)
  );

  cfg_word #(.RESET_VALUE(TURNOFF_RESET)) u_turnoff_threshold_config (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(wr_en && wr_sel == REG_SEL_TURNOFF),
    .wr_data(wr_data),
    .value(turnoff_word)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= (rd_sel == REG_SEL_TURNOFF) ? turnoff_word : enable_word; // R20
    end
  end

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  logic [1:0] switch_thermal_filter_time;
  logic desaturation_filter_time;
  logic [1:0] gate_monitor_blank_time;
  logic gate_monitor_off;
  logic desaturation_detect_on;
  logic short_circuit_guard_off;
  logic overcurrent_guard_off;
  logic switch_thermal_guard_on;
  logic gate_monitor_mute_in_turnoff;
  logic [1:0] blank_cap_charge_current;
  logic [1:0] miller_clamp_threshold;
  logic [2:0] fault_turnoff_mode;
  logic pwm_mute_on;

  assign switch_thermal_filter_time = enable_word[POS_THERMAL_FILTER_HI:POS_THERMAL_FILTER_LO];
  assign desaturation_filter_time = enable_word[POS_DESAT_FILTER];
  assign gate_monitor_blank_time = enable_word[POS_GM_BLANK_HI:POS_GM_BLANK_LO];
  assign gate_monitor_off = enable_word[POS_GATE_MONITOR_OFF];
  assign desaturation_detect_on = enable_word[POS_DESAT_DETECT_ON];
  assign short_circuit_guard_off = enable_word[POS_SHORT_CIRCUIT_OFF];
  assign overcurrent_guard_off = enable_word[POS_OVERCURRENT_OFF];
  assign switch_thermal_guard_on = enable_word[POS_SWITCH_THERMAL_ON];
  assign gate_monitor_mute_in_turnoff = turnoff_word[POS_GM_MUTE_TURNOFF];
  assign blank_cap_charge_current = turnoff_word[POS_CHARGE_CUR_HI:POS_CHARGE_CUR_LO];
  assign miller_clamp_threshold = turnoff_word[POS_MILLER_TH_HI:POS_MILLER_TH_LO];
  assign fault_turnoff_mode = turnoff_word[POS_TURNOFF_MODE_HI:POS_TURNOFF_MODE_LO];
  assign pwm_mute_on = turnoff_word[POS_PWM_MUTE_ON];

  // ----------------------------------------------------------------
  // static configuration outputs
  // ----------------------------------------------------------------
  assign sec_pos_undervolt_off = enable_word[POS_SEC_POS_UNDERVOLT_OFF]; // R1
  assign sec_pos_overvolt_off = enable_word[POS_SEC_POS_OVERVOLT_OFF]; // R4
  assign miller_clamp_source_select = enable_word[POS_MILLER_SOURCE]; // R5
  assign miller_clamp_off = enable_word[POS_MILLER_CLAMP_OFF]; // R8
  assign collector_clamp_on = enable_word[POS_COLLECTOR_CLAMP_ON];
  assign sec_neg_supply_lockout_on = enable_word[POS_SEC_NEG_LOCKOUT_ON]; // R12
  assign desaturation_pulldown_on = turnoff_word[POS_DESAT_PULLDOWN_ON]; // R16
  assign desaturation_threshold = turnoff_word[POS_DESAT_TH_HI:POS_DESAT_TH_LO];
  assign soft_turnoff_current = turnoff_word[POS_SOFT_CUR_HI:POS_SOFT_CUR_LO];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      desaturation_threshold_mv <= 16'h0000;
      blank_cap_charge_current_ua <= 16'h0000;
      miller_clamp_threshold_mv <= 16'h0000;
    end else begin
      desaturation_threshold_mv <= 16'(DESAT_TH_BASE_MV
                                   + int'(desaturation_threshold) * DESAT_TH_STEP_MV); // R14
      case (blank_cap_charge_current) // R15
        2'h0: blank_cap_charge_current_ua <= 16'h0258;
        2'h1: blank_cap_charge_current_ua <= 16'h02BC;
        2'h2: blank_cap_charge_current_ua <= 16'h0320;
        default: blank_cap_charge_current_ua <= 16'h03E8;
      endcase
      case (miller_clamp_threshold) // R17
        2'h0: miller_clamp_threshold_mv <= 16'h05DC;
        2'h1: miller_clamp_threshold_mv <= 16'h07D0;
        2'h2: miller_clamp_threshold_mv <= 16'h0BB8;
        default: miller_clamp_threshold_mv <= 16'h0FA0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;

  assign pin_raw = {pwm_in, gate_monitor_in, switch_thermal_in,
                    overcurrent_in, short_circuit_in, desat_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic desat_s, sc_s, oc_s, thermal_s, gm_s, pwm_s;
  assign {pwm_s, gm_s, thermal_s, oc_s, sc_s, desat_s} = pin_sync;

  // ----------------------------------------------------------------
  // deglitch filters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] thermal_limit;
  logic [CNT_W-1:0] desat_limit;
  logic [CNT_W-1:0] thermal_cnt;
  logic [CNT_W-1:0] desat_cnt;

  always_comb begin
    case (switch_thermal_filter_time) // R2
      2'h0: thermal_limit = ns_to_cycles(THERMAL_FILTER_NS_0);
      2'h1: thermal_limit = ns_to_cycles(THERMAL_FILTER_NS_1);
      2'h2: thermal_limit = ns_to_cycles(THERMAL_FILTER_NS_2);
      default: thermal_limit = ns_to_cycles(THERMAL_FILTER_NS_3);
    endcase
    desat_limit = desaturation_filter_time ? ns_to_cycles(DESAT_FILTER_NS_1)
                                           : ns_to_cycles(DESAT_FILTER_NS_0); // R3
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      thermal_cnt <= '0;
    end else if (!thermal_s) begin
      thermal_cnt <= '0;
    end else begin
      thermal_cnt <= count_step(thermal_cnt, thermal_limit); // R2
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      desat_cnt <= '0;
    end else if (!desat_s) begin
      desat_cnt <= '0;
    end else begin
      desat_cnt <= count_step(desat_cnt, desat_limit); // R3
    end
  end

  // ----------------------------------------------------------------
  // gate monitor blanking after each PWM rising or falling edge
  // ----------------------------------------------------------------
  logic pwm_prev;
  logic [CNT_W-1:0] blank_cnt;
  logic [CNT_W-1:0] blank_limit;

  always_comb begin
    case (gate_monitor_blank_time) // R6
      2'h0: blank_limit = ns_to_cycles(GM_BLANK_NS_0);
      2'h1: blank_limit = ns_to_cycles(GM_BLANK_NS_1);
      2'h2: blank_limit = ns_to_cycles(GM_BLANK_NS_2);
      default: blank_limit = ns_to_cycles(GM_BLANK_NS_3);
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwm_prev <= 1'b0;
      blank_cnt <= '0;
    end else begin
      pwm_prev <= pwm_s;
      if (pwm_s != pwm_prev) begin
        blank_cnt <= blank_limit; // R6
      end else if (blank_cnt != '0) begin
        blank_cnt <= blank_cnt - CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // fault qualification and turn-off requests
  // ----------------------------------------------------------------
  logic sc_q, oc_q, desat_q, thermal_q, covered;
  logic [1:0] cover_level;

  assign sc_q = sc_s && !short_circuit_guard_off; // R9
  assign oc_q = oc_s && !overcurrent_guard_off; // R10
  assign desat_q = desaturation_detect_on && desat_cnt >= desat_limit;
  assign thermal_q = switch_thermal_guard_on && thermal_cnt >= thermal_limit; // R11
  assign cover_level = fault_turnoff_mode[1:0];

  always_comb begin
    case (cover_level) // R18
      COVER_SC_DESAT: covered = sc_q || desat_q;
      COVER_PLUS_OC: covered = sc_q || desat_q || oc_q;
      COVER_PLUS_THERMAL: covered = sc_q || desat_q || oc_q || thermal_q;
      default: covered = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      short_circuit_fault <= 1'b0;
      overcurrent_fault <= 1'b0;
      desat_fault <= 1'b0;
      switch_thermal_fault <= 1'b0;
      soft_turnoff <= 1'b0;
      two_level_turnoff <= 1'b0;
    end else begin
      short_circuit_fault <= sc_q;
      overcurrent_fault <= oc_q;
      desat_fault <= desat_q;
      switch_thermal_fault <= thermal_q;
      soft_turnoff <= covered && !fault_turnoff_mode[MODE_TWO_LEVEL_BIT]; // R18
      two_level_turnoff <= covered && fault_turnoff_mode[MODE_TWO_LEVEL_BIT]; // R18
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gate_monitor_fault <= 1'b0;
    end else begin
      gate_monitor_fault <= gm_s && !gate_monitor_off // R7
                            && blank_cnt == '0 && pwm_s == pwm_prev
                            && !(gate_monitor_mute_in_turnoff
                                 && (soft_turnoff || two_level_turnoff)); // R13
    end
  end

  // ----------------------------------------------------------------
  // PWM muting
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] mute_cnt;
  logic mute_trigger;

  assign mute_trigger = pwm_mute_on && (sc_q || oc_q || thermal_q);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mute_cnt <= '0;
    end else if (mute_trigger) begin
      mute_cnt <= MUTE_CYCLES; // R19
    end else if (!pwm_mute_on) begin
      mute_cnt <= '0;
    end else if (mute_cnt != '0) begin
      mute_cnt <= mute_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= pwm_s && !mute_trigger && mute_cnt == '0; // R19
    end
  end

endmodule : gate_driver_protection_config
`default_nettype wire

//--- sim/gate_protect_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gate_protect_properties (
  input wire logic clk_sys, // clock
  input wire logic reset, // async reset
  input wire logic wr_en, // write strobe
  input wire logic wr_sel, // write target
  input wire logic [15:0] wr_data, // write data
  input wire logic short_circuit_in, // sc pin
  input wire logic desat_in, // desat pin
  input wire logic switch_thermal_in, // thermal pin
  input wire logic sec_pos_undervolt_off, // enable bit 15
  input wire logic sec_pos_overvolt_off, // enable bit 11
  input wire logic miller_clamp_off, // enable bit 6
  input wire logic desaturation_pulldown_on, // turnoff bit 8
  input wire logic [3:0] desaturation_threshold, // turnoff 14:11
  input wire logic [15:0] desaturation_threshold_mv, // decoded
  input wire logic short_circuit_fault, // sc fault
  input wire logic desat_fault, // desat fault
  input wire logic switch_thermal_fault, // thermal fault
  input wire logic soft_turnoff, // soft request
  input wire logic two_level_turnoff // two-level request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  uv_write_a: assert property (wr_en && !wr_sel |=> sec_pos_undervolt_off == $past(wr_data[15]))
    else $error("undervolt bit not written");
  ov_write_a: assert property (wr_en && !wr_sel |=> sec_pos_overvolt_off == $past(wr_data[11]))
    else $error("overvolt bit not written");
  clamp_write_a: assert property (wr_en && !wr_sel |=> miller_clamp_off == $past(wr_data[6]))
    else $error("clamp off bit not written");
  pulldown_write_a: assert property (wr_en && wr_sel |=> desaturation_pulldown_on == $past(wr_data[8]))
    else $error("pulldown bit not written");
  thresh_write_a: assert property (wr_en && wr_sel |=> desaturation_threshold == $past(wr_data[14:11]))
    else $error("threshold field not written");
  enable_hold_a: assert property (!(wr_en && !wr_sel) |=>
    $stable({sec_pos_undervolt_off, sec_pos_overvolt_off, miller_clamp_off}))
    else $error("enable fields changed without write");
  thresh_mv_a: assert property (!$past(reset) && !$past(reset, 2) |->
    desaturation_threshold_mv == 16'(2500 + 500 * $past(desaturation_threshold)))
    else $error("threshold mV decode wrong");
  // ----------------------------------------------------------------
  // fault path
  // ----------------------------------------------------------------
  sc_cause_a: assert property (short_circuit_fault |-> $past(short_circuit_in, 3))
    else $error("sc fault without pin");
  thermal_filt_a: assert property ($rose(switch_thermal_fault) |-> $past(switch_thermal_in, 45))
    else $error("thermal fault too early");
  desat_filt_a: assert property ($rose(desat_fault) |-> $past(desat_in, 30))
    else $error("desat fault too early");
  mode_excl_a: assert property (two_level_turnoff |-> !soft_turnoff)
    else $error("both turn-off kinds active");
  cover property (soft_turnoff);
  cover property (two_level_turnoff);
  cover property ($rose(desat_fault));
endmodule : gate_protect_properties
bind gate_driver_protection_config gate_protect_properties chk_u (.*);
`default_nettype wire

//--- sim/gate_driver_protection_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gate_driver_protection_config_tb;
  import gate_protect_pkg::*;
  logic clk_sys = 0, reset = 1, wr_en = 0, wr_sel = 0, rd_sel = 0, desat_in = 0;
  logic short_circuit_in = 0, overcurrent_in = 0, switch_thermal_in = 0;
  logic gate_monitor_in = 0, pwm_in = 0;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rd_data, desaturation_threshold_mv, blank_cap_charge_current_ua;
  logic [15:0] miller_clamp_threshold_mv;
  logic [3:0] desaturation_threshold;
  logic [1:0] soft_turnoff_current;
  logic sec_pos_undervolt_off, sec_pos_overvolt_off, miller_clamp_source_select;
  logic miller_clamp_off, collector_clamp_on, desaturation_pulldown_on;
  logic sec_neg_supply_lockout_on, desat_fault, short_circuit_fault, overcurrent_fault;
  logic switch_thermal_fault, gate_monitor_fault, soft_turnoff, two_level_turnoff, pwm_out;
  int errors = 0;
  int tests_run = 0;
  logic [15:0] chg [4] = '{16'h0258, 16'h02BC, 16'h0320, 16'h03E8};
  logic [15:0] mcl [4] = '{16'h05DC, 16'h07D0, 16'h0BB8, 16'h0FA0};

  gate_driver_protection_config dut_u (.*);

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wr(input logic s, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic s, input logic [15:0] e);
    @(posedge clk_sys);
    rd_sel <= s;
    cyc(1);
    chk("rd_data", rd_data, e);
  endtask : rd

  function automatic logic [15:0] pins;
    return {9'h000, sec_pos_undervolt_off, sec_pos_overvolt_off, miller_clamp_source_select,
      miller_clamp_off, collector_clamp_on, desaturation_pulldown_on, sec_neg_supply_lockout_on};
  endfunction : pins

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(1'b0, 16'h0934);
    rd(1'b1, 16'h7741);
    chk("pins", pins(), 16'h0026);
    chk("dec", {desaturation_threshold, 10'h000, soft_turnoff_current}, 16'hE000);
    chk("th_mv", desaturation_threshold_mv, 16'h251C);
    chk("chg", blank_cap_charge_current_ua, 16'h03E8);
    chk("mcl", miller_clamp_threshold_mv, 16'h07D0);
  endtask : t_reset

  task automatic t_rw;
    wr(1'b0, 16'hA5C3);
    wr(1'b1, 16'h5A3C);
    cyc(1);
    chk("pins", pins(), 16'h0059);
    chk("th", {12'h000, desaturation_threshold}, 16'h000B);
    rd(1'b0, 16'hA5C3);
    rd(1'b1, 16'h5A3C);
    wr(1'b0, 16'h5A3C);
    wr(1'b1, 16'hA5C3);
    rd(1'b0, 16'h5A3C);
    rd(1'b1, 16'hA5C3);
  endtask : t_rw

  task automatic t_decode;
    for (int c = 0; c < 16; c++) begin
      wr(1'b1, {1'b0, 4'(c), 2'(c), 1'b1, 2'(c), 2'(c), 4'h0});
      cyc(2);
      chk("th_mv", desaturation_threshold_mv, 16'h09C4 + 16'h01F4 * 16'(c));
      chk("chg", blank_cap_charge_current_ua, chg[c % 4]);
      chk("mcl", miller_clamp_threshold_mv, mcl[c % 4]);
    end
  endtask : t_decode

  task automatic t_modes;
    logic [2:0] m;
    logic cov;
    wr(1'b0, 16'h0930);
    for (int i = 0; i < 16; i++) begin
      m = 3'(i);
      cov = (m[1:0] != 2'h0) && (!i[3] || m[1]);
      wr(1'b1, {12'h774, m, 1'b0});
      @(posedge clk_sys);
      if (i[3]) overcurrent_in <= 1'b1;
      else short_circuit_in <= 1'b1;
      cyc(5);
      chk("toff", {13'h0000, short_circuit_fault | overcurrent_fault, soft_turnoff,
        two_level_turnoff}, {13'h0000, 1'b1, cov && !m[2], cov && m[2]});
      @(posedge clk_sys);
      overcurrent_in <= 1'b0;
      short_circuit_in <= 1'b0;
      cyc(5);
    end
    wr(1'b0, 16'h093C);
    @(posedge clk_sys);
    overcurrent_in <= 1'b1;
    short_circuit_in <= 1'b1;
    cyc(5);
    chk("off", {14'h0000, short_circuit_fault, overcurrent_fault}, 16'h0000);
    @(posedge clk_sys);
    overcurrent_in <= 1'b0;
    short_circuit_in <= 1'b0;
    cyc(5);
  endtask : t_modes

  task automatic t_mute;
    wr(1'b0, 16'h0930);
    wr(1'b1, 16'h7743);
    @(posedge clk_sys);
    pwm_in <= 1'b1;
    cyc(5);
    chk("pwm", {15'h0000, pwm_out}, 16'h0001);
    short_circuit_in <= 1'b1;
    cyc(5);
    chk("pwm", {15'h0000, pwm_out}, 16'h0000);
    short_circuit_in <= 1'b0;
    cyc(100);
    chk("pwm", {15'h0000, pwm_out}, 16'h0000);
    cyc(120);
    chk("pwm", {15'h0000, pwm_out}, 16'h0001);
    wr(1'b1, 16'h7742);
    @(posedge clk_sys);
    short_circuit_in <= 1'b1;
    cyc(5);
    chk("pwm", {15'h0000, pwm_out}, 16'h0001);
    short_circuit_in <= 1'b0;
    cyc(5);
  endtask : t_mute

  task automatic t_gm;
    wr(1'b0, 16'h0830);
    @(posedge clk_sys);
    gate_monitor_in <= 1'b1;
    pwm_in <= ~pwm_in;
    cyc(90);
    chk("gm", {15'h0000, gate_monitor_fault}, 16'h0000);
    cyc(20);
    chk("gm", {15'h0000, gate_monitor_fault}, 16'h0001);
    wr(1'b1, 16'hF742);
    @(posedge clk_sys);
    short_circuit_in <= 1'b1;
    cyc(6);
    chk("gm", {15'h0000, gate_monitor_fault}, 16'h0000);
    short_circuit_in <= 1'b0;
    wr(1'b0, 16'h08B0);
    cyc(4);
    chk("gm", {15'h0000, gate_monitor_fault}, 16'h0000);
    gate_monitor_in <= 1'b0;
  endtask : t_gm

  task automatic t_filt(input logic th, input int code);
    int lim;
    lim = th ? 50 * (code + 1) : 32 * (code + 1);
    wr(1'b0, th ? (16'h0932 | 16'(code << 13)) : (16'h0930 | 16'(code << 12)));
    @(posedge clk_sys);
    if (th) switch_thermal_in <= 1'b1;
    else desat_in <= 1'b1;
    cyc(lim - 2);
    chk("filt", {15'h0000, th ? switch_thermal_fault : desat_fault}, 16'h0000);
    cyc(10);
    chk("filt", {15'h0000, th ? switch_thermal_fault : desat_fault}, 16'h0001);
    switch_thermal_in <= 1'b0;
    desat_in <= 1'b0;
    cyc(6);
  endtask : t_filt

  initial begin
    #200000;
    errors++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_rw();
    t_decode();
    t_modes();
    t_mute();
    t_gm();
    for (int c = 0; c < 4; c++) t_filt(1'b1, c);
    for (int c = 0; c < 2; c++) t_filt(1'b0, c);
    finish_test();
  end
endmodule : gate_driver_protection_config_tb
`default_nettype wire
